/* File: hw/fbs_pkg.sv */
// Purpose: shared constants and types for the flow-through burst sram core
// Assumes: one clock, synchronous active-high reset, pins resynchronised inside
// Notes:   control pins travel as one vector inside the core, positions below
//
// Functional notes
// [R01] load with any chip select inactive deselects and floats data; advance continues only a deselect
// [R02] all selects active, load, read high, output enable on: read at external address
// [R03] advance during read reads next burst address, ignoring selects and read/write
// [R04] output enable off during read: address still steps, data pins stay floating
// [R05] all selects active, load, write, some byte enable low: write at external address
// [R06] all byte enables high on write begin or continue: nothing stored, pins float
// [R07] continue cycles keep the read or write type chosen at load
// [R08] clock gate high holds state and address, no write, read drive kept
// [R09] data drivers are off during writes whatever output enable says
// [R10] each low byte enable writes only its own lane a to d
// [R11] two-bit burst counter wraps to the start address every fourth cycle
// [R12] burst counter steps on every continue cycle, dummy reads and aborts too
// [R13] all inputs except output enable are sampled on the rising clock edge; the core samples output enable on that edge too
// [R14] data outputs float from power-up until a read is issued
// [R15] burst order high gives interleaved xor order, low gives linear order
// [R16] array holds 65536 words of 36 bits, low two address bits burst
package fbs_pkg;
	// ==========================================================================
	// sizes
	localparam int ADDR_W     = 16;
	localparam int DATA_W     = 36;
	localparam int LANES      = 4;
	localparam int BURST_W    = 2;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================================
	// control vector field positions
	localparam int CTL_W      = 12;
	localparam int CTL_CE0N   = 0;
	localparam int CTL_CE1    = 1;
	localparam int CTL_CE2N   = 2;
	localparam int CTL_ADV    = 3;
	localparam int CTL_RW     = 4;
	localparam int CTL_BW_LO  = 5;
	localparam int CTL_GATEN  = 9;
	localparam int CTL_OEN    = 10;
	localparam int CTL_LBO    = 11;
	// reset value: deselected, clock gated, output enable off, interleaved
	localparam logic [CTL_W-1:0] CTL_RST = 12'he01;

	// ==========================================================================
	// burst state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} fbs_state_t;
endpackage

/* File: hw/fbs_core.sv */
// Purpose: command decode, burst sequencing and storage of the burst sram
// Assumes: every pin passes two flip-flops first, so answers trail pins by three edges
// Notes:   writes queue in a fifo and drain while the clock gate is open
`timescale 1ns/10ps

// ==========================================================================
// fifo
module fbs_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         clk_en_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_reg;
	logic [PW-1:0] rd_reg;
	logic [PW:0]   cnt_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem_reg[rd_reg];
	assign push        = clk_en_i & in_valid_i & in_ready_o;
	assign pop         = clk_en_i & out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ==========================================================================
// core
module fbs_core #(
	parameter int ADDR_W = fbs_pkg::ADDR_W,
	parameter int DATA_W = fbs_pkg::DATA_W
) (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 clk_en_i,
	input  wire logic                 chip_sel_low_a_n_i,
	input  wire logic                 chip_sel_high_i,
	input  wire logic                 chip_sel_low_b_n_i,
	input  wire logic                 advance_or_load_i,
	input  wire logic                 read_write_i,
	input  wire logic [3:0]           byte_write_enables_n_i,
	input  wire logic                 clock_gate_n_i,
	input  wire logic                 out_en_n_i,
	input  wire logic                 burst_order_select_i,
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic [DATA_W-1:0]    dq_i,
	output logic [DATA_W-1:0]         dq_o,
	output logic                      dq_oe_o
);
	localparam int BW = fbs_pkg::BURST_W;
	localparam int LW = DATA_W / fbs_pkg::LANES;
	localparam int EW = ADDR_W + DATA_W + fbs_pkg::LANES;

	// ==========================================================================
	// pin synchronisers
	logic [fbs_pkg::CTL_W-1:0] ctl_m_reg;
	logic [fbs_pkg::CTL_W-1:0] ctl_reg;
	logic [ADDR_W-1:0]         addr_m_reg;
	logic [ADDR_W-1:0]         addr_reg;
	logic [DATA_W-1:0]         din_m_reg;
	logic [DATA_W-1:0]         din_reg;

	always_ff @(posedge clk_i) begin // [R13]
		if (sys_rst_i) begin
			ctl_m_reg <= fbs_pkg::CTL_RST;
			ctl_reg   <= fbs_pkg::CTL_RST;
		end else if (clk_en_i) begin
			ctl_m_reg <= {burst_order_select_i, out_en_n_i, clock_gate_n_i, byte_write_enables_n_i,
				read_write_i, advance_or_load_i, chip_sel_low_b_n_i, chip_sel_high_i, chip_sel_low_a_n_i};
			ctl_reg   <= ctl_m_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (clk_en_i) begin
			addr_m_reg <= addr_i;
			addr_reg   <= addr_m_reg;
			din_m_reg  <= dq_i;
			din_reg    <= din_m_reg;
		end
	end

	logic       sel;
	logic       adv_s;
	logic       rd_s;
	logic       gate_s;
	logic       oe_s;
	logic       lbo_s;
	logic [3:0] bwn_s;
	logic       any_bw;

	assign sel    = ~ctl_reg[fbs_pkg::CTL_CE0N] & ctl_reg[fbs_pkg::CTL_CE1] & ~ctl_reg[fbs_pkg::CTL_CE2N];
	assign adv_s  = ctl_reg[fbs_pkg::CTL_ADV];
	assign rd_s   = ctl_reg[fbs_pkg::CTL_RW];
	assign gate_s = ctl_reg[fbs_pkg::CTL_GATEN];
	assign oe_s   = ~ctl_reg[fbs_pkg::CTL_OEN];
	assign lbo_s  = ctl_reg[fbs_pkg::CTL_LBO];
	assign bwn_s  = ctl_reg[fbs_pkg::CTL_BW_LO +: 4];
	assign any_bw = ~&bwn_s;

	// ==========================================================================
	// burst address order
	function automatic logic [BW-1:0] burst_off(input logic burst_order_select, input logic [BW-1:0] base,
		input logic [BW-1:0] cnt);
		burst_off = burst_order_select ? (base ^ cnt) : (base + cnt); // [R15]
	endfunction

	// ==========================================================================
	// command decode
	fbs_pkg::fbs_state_t     st_reg;
	fbs_pkg::fbs_state_t     st_next;
	logic [ADDR_W-BW-1:0]    hi_reg;
	logic [ADDR_W-BW-1:0]    hi_next;
	logic [BW-1:0]           base_reg;
	logic [BW-1:0]           base_next;
	logic [BW-1:0]           cnt_reg;
	logic [BW-1:0]           cnt_next;
	logic [ADDR_W-1:0]       acc_addr;
	logic                    rd_acc;
	logic                    push;
	logic                    act;
	logic                    stall;
	logic                    go;
	logic                    q_in_ready;
	logic                    q_out_valid;
	logic [EW-1:0]           q_out;
	logic [DATA_W-1:0]       rd_word;

	always_comb begin
		st_next   = st_reg;
		hi_next   = hi_reg;
		base_next = base_reg;
		cnt_next  = cnt_reg;
		acc_addr  = {hi_reg, burst_off(lbo_s, base_reg, cnt_reg + 1'b1)};
		rd_acc    = 1'b0;
		push      = 1'b0;
		if (!adv_s) begin
			acc_addr = addr_reg;
			if (!sel) begin
				st_next = fbs_pkg::ST_IDLE; // [R01]
			end else begin
				hi_next   = addr_reg[ADDR_W-1:BW];
				base_next = addr_reg[BW-1:0];
				cnt_next  = '0;
				if (rd_s) begin
					st_next = fbs_pkg::ST_READ; // [R02]
					rd_acc  = 1'b1;
				end else begin
					st_next = fbs_pkg::ST_WRITE; // [R05]
					push    = any_bw; // [R06]
				end
			end
		end else begin
			unique case (st_reg) // [R07]
				fbs_pkg::ST_IDLE: begin
					st_next = fbs_pkg::ST_IDLE; // [R01]
				end
				fbs_pkg::ST_READ: begin
					cnt_next = cnt_reg + 1'b1; // [R11] [R12]
					rd_acc   = 1'b1; // [R03]
				end
				fbs_pkg::ST_WRITE: begin
					cnt_next = cnt_reg + 1'b1; // [R11] [R12]
					push     = any_bw; // [R06]
				end
				default: begin
					st_next = fbs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// a read that meets queued writes is stalled and dropped, so it never sees stale data
	assign act   = clk_en_i & ~gate_s; // [R08]
	assign stall = (rd_acc & q_out_valid) | (push & ~q_in_ready);
	assign go    = act & ~stall;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg   <= fbs_pkg::ST_IDLE;
			hi_reg   <= '0;
			base_reg <= '0;
			cnt_reg  <= '0;
		end else if (go) begin
			st_reg   <= st_next;
			hi_reg   <= hi_next;
			base_reg <= base_next;
			cnt_reg  <= cnt_next;
		end
	end

	// ==========================================================================
	// write queue and array
	fbs_fifo #(
		.W     (EW),
		.DEPTH (fbs_pkg::FIFO_DEPTH)
	) u_wq (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.clk_en_i    (clk_en_i),
		.in_valid_i  (go & push),
		.in_ready_o  (q_in_ready),
		.in_data_i   ({acc_addr, din_reg, bwn_s}),
		.out_valid_o (q_out_valid),
		.out_ready_i (~gate_s), // [R08]
		.out_data_o  (q_out)
	);

	logic              drain;
	logic [ADDR_W-1:0] w_addr;

	assign drain  = clk_en_i & ~gate_s & q_out_valid;
	assign w_addr = q_out[EW-1 -: ADDR_W];

	// one array per lane, so every lane has a single writing process
	for (genvar l = 0; l < fbs_pkg::LANES; l++) begin : g_lane
		logic [LW-1:0] lane_reg [2**ADDR_W]; // [R16]

		always_ff @(posedge clk_i) begin
			if (drain && !q_out[l]) begin
				lane_reg[w_addr] <= q_out[fbs_pkg::LANES + l*LW +: LW]; // [R10]
			end
		end

		assign rd_word[l*LW +: LW] = lane_reg[acc_addr];
	end

	// ==========================================================================
	// data output
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dq_o    <= '0;
			dq_oe_o <= 1'b0; // [R14]
		end else if (clk_en_i) begin
			if (go) begin
				if (rd_acc) begin
					dq_o <= rd_word;
				end
				dq_oe_o <= rd_acc & oe_s; // [R04] [R09]
			end else begin
				dq_oe_o <= (st_reg == fbs_pkg::ST_READ) & oe_s & ~stall; // [R08]
			end
		end
	end

	// ==========================================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_rd_load;
		go && !adv_s && sel && rd_s;
	endsequence

	sequence s_continue;
		go && adv_s && st_reg != fbs_pkg::ST_IDLE;
	endsequence

	chk_deselect_float: assert property (go && !adv_s && !sel |=> !dq_oe_o) // [R01]
		else $error("deselect left data driven");
	chk_read_begin: assert property (s_rd_load ##0 oe_s |=> dq_oe_o && dq_o == $past(rd_word)) // [R02]
		else $error("read begin did not drive array word");
	chk_read_next: assert property (go && adv_s && st_reg == fbs_pkg::ST_READ && oe_s |=> dq_oe_o) // [R03]
		else $error("read continue did not drive");
	chk_dummy_read: assert property (go && rd_acc && !oe_s |=> !dq_oe_o) // [R04]
		else $error("dummy read drove data");
	chk_write_push: assert property (go && !adv_s && sel && !rd_s |-> push == any_bw) // [R05]
		else $error("write begin queued wrongly");
	chk_write_abort: assert property (go && st_next == fbs_pkg::ST_WRITE && &bwn_s |-> !push) // [R06]
		else $error("write abort stored data");
	chk_keep_type: assert property (s_continue |=> st_reg == $past(st_reg)) // [R07]
		else $error("continue changed burst type");
	chk_gate_hold: assert property (gate_s && st_reg == fbs_pkg::ST_READ && oe_s |=> $stable(dq_o) && dq_oe_o) // [R08]
		else $error("gated read lost output");
	chk_gate_nowrite: assert property (gate_s |-> !drain && !(go && push)) // [R08]
		else $error("write while clock gated");
	chk_write_float: assert property (st_reg == fbs_pkg::ST_WRITE |-> !dq_oe_o) // [R09]
		else $error("data driven during write");
	chk_burst_step: assert property (s_continue |=> cnt_reg == $past(cnt_reg) + 2'h1) // [R11] [R12]
		else $error("burst counter did not step");
	chk_reset_float: assert property (disable iff (1'b0) $past(sys_rst_i) && !sys_rst_i |-> !dq_oe_o) // [R14]
		else $error("outputs driven after reset");
endmodule

/* File: tb/fbs_master_model.sv */
// Purpose: bus master side of the shared data wire of the burst sram core
// Assumes: the master drives the wire only during its own write beats
// Notes:   a released wire shows the inverse of its last level
`timescale 1ns/10ps

// ==========================================================================
// data wire
module fbs_master_model (
	input  wire logic                       clk_i,
	input  wire logic                       drv_i,
	input  wire logic [fbs_pkg::DATA_W-1:0] data_i,
	input  wire logic [fbs_pkg::DATA_W-1:0] core_dq_i,
	input  wire logic                       core_oe_i,
	output logic [fbs_pkg::DATA_W-1:0]      wire_o
);
	logic [fbs_pkg::DATA_W-1:0] last_reg = '0;

	// no keeper on the wire, so a floating bus must never pass for held data
	always_ff @(posedge clk_i) begin
		last_reg <= wire_o;
	end

	always_comb begin
		if (drv_i) begin
			wire_o = data_i;
		end else if (core_oe_i) begin
			wire_o = core_dq_i;
		end else begin
			wire_o = ~last_reg;
		end
	end
endmodule

/* File: tb/fbs_core_tb_top.sv */
// Purpose: self-checking bench for the burst sram core
// Assumes: answers trail the pins by three edges; writes drain within four idle cycles
// Notes:   pins change on the falling edge; clk_en_i is tied high
`timescale 1ns/10ps

// ==========================================================================
// bench
module fbs_core_tb_top;
	logic        clk_i     = 0;
	logic        sys_rst_i = 1;
	logic        csa_n, csh, csb_n, adv, rw, gate_n, oe_n, burst_order_select, drv, dq_oe_o;
	logic [3:0]  bw;
	logic [15:0] addr, base;
	logic [1:0]  cnt;
	logic [35:0] wdata, dq_i, dq_o;
	logic [35:0] mem [0:65535];
	logic [36:0] expq [$];
	logic [36:0] last_e;
	int          typ, n_fail, tests_run, cyc;

	always #20 clk_i = ~clk_i;

	fbs_core fbs_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
		.chip_sel_low_a_n_i(csa_n), .chip_sel_high_i(csh), .chip_sel_low_b_n_i(csb_n),
		.advance_or_load_i(adv), .read_write_i(rw), .byte_write_enables_n_i(bw),
		.clock_gate_n_i(gate_n), .out_en_n_i(oe_n), .burst_order_select_i(burst_order_select),
		.addr_i(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

	fbs_master_model fbs_master_model_i (.clk_i(clk_i), .drv_i(drv), .data_i(wdata),
		.core_dq_i(dq_o), .core_oe_i(dq_oe_o), .wire_o(dq_i));

	// ==========================================================================
	// reporting
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// a hung core must still reach the verdict
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			summarize();
		end
	end

	// ==========================================================================
	// one pin cycle: op 0 load, 1 advance, 2 clock gated; s marks active selects
	task automatic step(input int op, input logic [2:0] s, input logic r, input logic [3:0] b,
		input logic [15:0] a, input logic [35:0] d);
		logic [36:0] e;
		logic [15:0] wa;
		if (expq.size() == 3) begin
			e = expq.pop_front();
			check("dq_oe_o", {35'h0, dq_oe_o}, {35'h0, e[36]});
			if (e[36]) check("dq_o", dq_o, e[35:0]);
		end
		if (op == 0) begin
			typ = (s != 3'b111) ? 0 : (r ? 1 : 2);
			base = a;
			cnt = 0;
		end else if (op == 1 && typ != 0) begin
			cnt++;
		end
		wa = {base[15:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
		e = 37'h0;
		if (op == 2) begin
			e = (typ == 1) ? last_e : 37'h0;
		end else if (typ == 2) begin
			for (int i = 0; i < 4; i++) if (!b[i]) mem[wa][i*9 +: 9] = d[i*9 +: 9];
		end else if (typ == 1 && !oe_n) begin
			e = {1'b1, mem[wa]};
		end
		last_e = e;
		expq.push_back(e);
		csa_n = ~s[0];
		csh = s[1];
		csb_n = ~s[2];
		adv = (op == 1);
		rw = r;
		bw = b;
		addr = a;
		gate_n = (op == 2);
		wdata = d;
		drv = (typ == 2);
		@(negedge clk_i);
	endtask

	task automatic ld(input logic r, input logic [3:0] b, input logic [15:0] a, input logic [35:0] d);
		step(0, 3'b111, r, b, a, d);
	endtask

	// advance beats carry junk selects and address; they must be ignored
	task automatic ad(input logic r, input logic [3:0] b, input logic [35:0] d);
		step(1, 3'b000, r, b, 16'hffff, d);
	endtask

	task automatic ds(input logic [2:0] s);
		step(0, s, 1'b1, 4'hf, 16'h0, 36'h0);
	endtask

	task automatic wb(input logic [15:0] a);
		ld(0, 4'h0, a, {8'h5a, a, 12'h0});
		for (int i = 1; i < 4; i++) ad(1, 4'h0, {8'h5a, a, 10'h0, 2'(i)});
		repeat (4) ds(3'b000);
	endtask

	task automatic rb(input logic [15:0] a);
		ld(1, 4'h0, a, 36'h0);
		for (int i = 1; i < 4; i++) ad(0, 4'h0, 36'h0);
		repeat (4) ds(3'b000);
	endtask

	// ==========================================================================
	// tests
	initial begin
		oe_n = 0;
		burst_order_select = 1;
		repeat (3) ds(3'b000);
		sys_rst_i = 0;
		check("dq_oe_o", {35'h0, dq_oe_o}, 36'h0);
		for (int k = 0; k < 3; k++) ds(3'b111 ^ (3'b001 << k));
		wb(16'h1231);
		ld(0, 4'b1010, 16'h1231, 36'h333333333);
		ad(1, 4'hf, 36'h444444444);
		step(2, 3'b000, 1'b1, 4'h0, 16'hffff, 36'h555555555);
		ad(1, 4'h0, 36'h666666666);
		repeat (4) ds(3'b000);
		ld(1, 4'h0, 16'h1231, 36'h0);
		ad(0, 4'h0, 36'h0);
		step(2, 3'b000, 1'b0, 4'h0, 16'hffff, 36'h0);
		oe_n = 1;
		ad(0, 4'h0, 36'h0);
		oe_n = 0;
		ad(0, 4'h0, 36'h0);
		ad(0, 4'h0, 36'h0);
		repeat (4) ds(3'b000);
		burst_order_select = 0;
		wb(16'h4562);
		rb(16'h4562);
		ds(3'b000);
		ad(0, 4'h0, 36'h777777777);
		ad(0, 4'h0, 36'h888888888);
		repeat (4) ds(3'b000);
		rb(16'h4562);
		summarize();
	end
endmodule
